// ===== rtl/pcr_defines.svh
// Register offsets, field positions, reset values and timing counts of the config block
// How it works
// - Startup range select: 0.5 ms or 1 ms steps
// - Shutdown range select: 0.5 ms or 1 ms steps
// - Four-bit delay code, zero means no delay
// - Clock pin is second output or clock input
// - Clock pin pull-down follows its select bit
// - Enable pin pull-down follows its select bit
// - Thermal warning threshold 125 or 137 degrees
// - Spread modulation follows its enable bit
// - PLL off means internal oscillator only
// - PLL on uses external clock when present and the clock pin is set as clock input
// - Event on external clock appear and disappear
// - Frequency code means code plus one MHz
// - Polarity bit sets active level of power good
// - Power good push-pull or open-drain by bit
// - Linear regulator window bit adds overvoltage check
// - Switcher window bit adds overvoltage check
// - Per-regulator enable bits select monitored regulators
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

`define PCR_ADDR_DEVICE_CONFIG 8'h13
`define PCR_ADDR_CLOCK_SYNC_CONTROL 8'h14
`define PCR_ADDR_POWER_GOOD_CONTROL 8'h15

`define PCR_CFG_STARTUP_RANGE 6
`define PCR_CFG_SHUTDOWN_RANGE 5
`define PCR_CFG_PIN_FUNCTION 4
`define PCR_CFG_CLOCK_PIN_PD 3
`define PCR_CFG_ENABLE_PIN_PD 2
`define PCR_CFG_THERMAL_LEVEL 1
`define PCR_CFG_SPREAD 0
`define PCR_CFG_WRITE_MASK 8'h7F

`define PCR_PLL_ENABLE 6
`define PCR_PLL_FREQ_MSB 4
`define PCR_PLL_WRITE_MASK 8'h5F
`define PCR_FREQ_OFFSET 6'h01

`define PCR_PG_POLARITY 7
`define PCR_PG_OPEN_DRAIN 6
`define PCR_PG_LINEAR_WINDOW 5
`define PCR_PG_SWITCHER_WINDOW 4
`define PCR_PG_SOURCE_MSB 3
`define PCR_PG_WRITE_MASK 8'hFF

`define PCR_REG_RESET 8'h00
`define PCR_UNMAPPED_DATA 8'h00
`define PCR_I2C_DEV_ADDR 7'h60
`define PCR_BITS_PER_BYTE 4'h8

`define PCR_CLK_PERIOD_NS 10
`define PCR_STEP_TIME_US 500
`define PCR_STEP_CYC ((`PCR_STEP_TIME_US * 1000) / `PCR_CLK_PERIOD_NS)
`define PCR_CLK_LOSS_TIME_NS 1500
`define PCR_CLK_LOSS_CYC (`PCR_CLK_LOSS_TIME_NS / `PCR_CLK_PERIOD_NS)

`endif

// ===== rtl/pcr_pkg.sv
// Types shared by the config block modules
package pcr_pkg;

  typedef enum logic [8:0] {
    I2C_IDLE      = 9'h001,
    I2C_ADDR      = 9'h002,
    I2C_ACK_ADDR  = 9'h004,
    I2C_REG       = 9'h008,
    I2C_ACK_REG   = 9'h010,
    I2C_WDATA     = 9'h020,
    I2C_ACK_WDATA = 9'h040,
    I2C_RDATA     = 9'h080,
    I2C_ACK_RDATA = 9'h100
  } pcr_i2c_state_t;

endpackage

// ===== rtl/pcr_delay_if.sv
// Request and completion signals between the sequencer and a delay timer
`timescale 1ns/10ps
interface pcr_delay_if;
  logic start;
  logic [3:0] code;
  logic wideStep;
  logic busy;
  logic done;
  modport ctrl (output start, output code, output wideStep, input busy, input done);
  modport timer (input start, input code, input wideStep, output busy, output done);
endinterface

// ===== rtl/pcr_delay_timer.sv
// Delay timer counting a four-bit code in half or whole steps
`timescale 1ns/10ps
`include "pcr_defines.svh"
module pcr_delay_timer
  import pcr_pkg::*;
#(
  parameter int unsigned STEP_CYC = `PCR_STEP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Delay request
  pcr_delay_if.timer dly
);
  localparam int unsigned TW = $clog2(STEP_CYC + 1);
  logic [TW-1:0] tick_r;
  logic [4:0] steps_r;
  logic busy_r;
  logic done_r;
  int unsigned elapsed_r;
  int unsigned half_r;

  assign dly.busy = busy_r;
  assign dly.done = done_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_r <= '0;
      steps_r <= '0;
      busy_r <= 1'h0;
      done_r <= 1'h0;
    end else begin
      done_r <= 1'h0;
      if (dly.start) begin
        steps_r <= dly.wideStep ? {dly.code, 1'h0} : {1'h0, dly.code};
        tick_r <= '0;
        busy_r <= (dly.code != 4'h0);
        done_r <= (dly.code == 4'h0);
      end else if (busy_r) begin
        if (tick_r == TW'(STEP_CYC - 1)) begin
          tick_r <= '0;
          steps_r <= steps_r - 5'h01;
          if (steps_r == 5'h01) begin
            busy_r <= 1'h0;
            done_r <= 1'h1;
          end
        end else begin
          tick_r <= tick_r + TW'(1);
        end
      end
    end
  end

  // Helper counters for the checks below
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      elapsed_r <= 0;
      half_r <= 0;
    end else if (dly.start) begin
      elapsed_r <= 1;
      half_r <= dly.wideStep ? 2 * int'(dly.code) : int'(dly.code);
    end else if (busy_r) begin
      elapsed_r <= elapsed_r + 1;
    end
  end

  property p_delay_length;
    @(posedge core_clk) disable iff (!rst_n)
      done_r |-> (elapsed_r == half_r * STEP_CYC + 1) || (half_r == 0 && elapsed_r == 1);
  endproperty
  a_delay_length: assert property (p_delay_length) else $error("delay length wrong");

  property p_wide_doubles;
    @(posedge core_clk) disable iff (!rst_n)
      dly.start && dly.wideStep && dly.code == 4'hF |=> steps_r == 5'h1E;
  endproperty
  a_wide_doubles: assert property (p_wide_doubles) else $error("wide step not doubled");

  property p_zero_code;
    @(posedge core_clk) disable iff (!rst_n)
      dly.start && dly.code == 4'h0 |=> done_r && !busy_r;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("zero code not immediate");

  c_full_delay: cover property (@(posedge core_clk) disable iff (!rst_n) done_r && half_r == 30);
endmodule

// ===== rtl/pcr_clock_monitor.sv
// Presence detector for the external clock and source selection
`timescale 1ns/10ps
`include "pcr_defines.svh"
module pcr_clock_monitor
  import pcr_pkg::*;
#(
  parameter int unsigned LOSS_CYC = `PCR_CLK_LOSS_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pin and control
  input wire logic externalClockInputPin,
  input wire logic pllEnable,
  input wire logic pinIsClock,
  // Status
  output logic useExternalClock,
  output logic clockEventPulse
);
  localparam int unsigned LW = $clog2(LOSS_CYC + 1);
  logic s1_r, s2_r, s3_r, filt_r, filtPrev_r;
  logic [LW-1:0] idle_r;
  logic present_r;
  logic event_r;
  logic watch;
  logic toggle;

  assign watch = pllEnable & pinIsClock;
  assign toggle = filt_r ^ filtPrev_r;
  assign useExternalClock = present_r;
  assign clockEventPulse = event_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
      s3_r <= 1'h0;
      filt_r <= 1'h0;
      filtPrev_r <= 1'h0;
    end else begin
      s1_r <= externalClockInputPin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        filt_r <= s3_r;
      end
      filtPrev_r <= filt_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idle_r <= '0;
      present_r <= 1'h0;
      event_r <= 1'h0;
    end else begin
      event_r <= 1'h0;
      if (!watch) begin
        idle_r <= '0;
        present_r <= 1'h0;
      end else if (toggle) begin
        idle_r <= '0;
        if (!present_r) begin
          present_r <= 1'h1;
          event_r <= 1'h1;
        end
      end else if (idle_r == LW'(LOSS_CYC - 1)) begin
        if (present_r) begin
          present_r <= 1'h0;
          event_r <= 1'h1;
        end
      end else begin
        idle_r <= idle_r + LW'(1);
      end
    end
  end

  property p_pll_off;
    @(posedge core_clk) disable iff (!rst_n) !pllEnable |=> !useExternalClock && !clockEventPulse;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("external clock used with PLL off");

  property p_auto_switch;
    @(posedge core_clk) disable iff (!rst_n)
      watch && !present_r && toggle |=> useExternalClock && clockEventPulse;
  endproperty
  a_auto_switch: assert property (p_auto_switch) else $error("no switch to external clock");

  property p_event_cause;
    @(posedge core_clk) disable iff (!rst_n)
      clockEventPulse |-> $past(watch) && (useExternalClock != $past(present_r));
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("clock event without change");

  c_clock_lost: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(useExternalClock) && clockEventPulse);
endmodule

// ===== rtl/pcr_config_regs.sv
// Configuration, clock source and power-good registers behind the serial management port
`timescale 1ns/10ps
`include "pcr_defines.svh"
module pcr_config_regs
  import pcr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `PCR_I2C_DEV_ADDR,
  parameter int unsigned STEP_CYC = `PCR_STEP_CYC,
  parameter int unsigned LOSS_CYC = `PCR_CLK_LOSS_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial management bus, open drain data
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Enable pin and sequencing
  input wire logic enablePin,
  input wire logic [3:0] startupDelayCode,
  input wire logic [3:0] shutdownDelayCode,
  output logic enablePinPulldownEnable,
  output logic sequencedEnable,
  // Clock-input pin
  input wire logic externalClockInputPin,
  input wire logic secondGeneralOutputLevel,
  output logic secondGeneralOutput,
  output logic secondGeneralOutputOe,
  output logic clockPinPulldownEnable,
  // Clock source
  output logic pllEnable,
  output logic useExternalClock,
  output logic clockEventPulse,
  output logic [5:0] expectedClockMhz,
  // Thermal and spread
  output logic thermalWarningThresholdSelect,
  output logic spreadModulationEnable,
  // Power good, bits are linear 1, linear 0, switcher 1, switcher 0
  input wire logic [3:0] railUnderVoltage,
  input wire logic [3:0] railOverVoltage,
  output logic powerOkOutput,
  output logic powerOkOe
);
  localparam int unsigned SW = 11;

  // Pin synchronisers
  logic [SW-1:0] s1_r, s2_r, s3_r, filt_r;
  logic sclF, sdaF, enF;
  logic [3:0] underF, overF;

  // Serial engine
  pcr_i2c_state_t state_r;
  logic sclPrev_r, sdaPrev_r;
  logic sclRise, sclFall, startCond, stopCond;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic [7:0] regAddr_r;
  logic readMode_r;
  logic sdaLow_r;
  logic byteDone;
  logic regWrite;
  logic [7:0] rdData;

  // Register file
  logic [7:0] devCfg_r;
  logic [7:0] clkCtl_r;
  logic [7:0] pgCtl_r;

  // Sequencing
  logic enPrev_r;
  logic seqEn_r;
  pcr_delay_if upIf ();
  pcr_delay_if downIf ();

  // Pins and power good
  logic gpoOut_r;
  logic [3:0] windowMask;
  logic [3:0] railOk;
  logic allGood;
  logic pgLevel_r;
  logic pgOut_r;
  logic pgOe_r;

  // Three-stage synchroniser, a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= {1'h1, 1'h1, {(SW-2){1'h0}}};
    end else begin
      s1_r <= {sclIn, sdaIn, enablePin, railUnderVoltage, railOverVoltage};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s3_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
    end
  end

  assign {sclF, sdaF, enF, underF, overF} = filt_r;

  // Bus conditions
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclPrev_r <= 1'h1;
      sdaPrev_r <= 1'h1;
    end else begin
      sclPrev_r <= sclF;
      sdaPrev_r <= sdaF;
    end
  end

  assign sclRise = sclF & ~sclPrev_r;
  assign sclFall = ~sclF & sclPrev_r;
  assign startCond = sclF & sclPrev_r & sdaPrev_r & ~sdaF;
  assign stopCond = sclF & sclPrev_r & ~sdaPrev_r & sdaF;
  assign byteDone = sclFall && (bitCnt_r == `PCR_BITS_PER_BYTE);
  assign regWrite = (state_r == I2C_WDATA) && byteDone;

  // Serial engine: address, register pointer, write bytes, read bytes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= I2C_IDLE;
      shift_r <= '0;
      bitCnt_r <= '0;
      regAddr_r <= '0;
      readMode_r <= 1'h0;
      sdaLow_r <= 1'h0;
    end else if (startCond) begin
      state_r <= I2C_ADDR;
      bitCnt_r <= '0;
      sdaLow_r <= 1'h0;
    end else if (stopCond) begin
      state_r <= I2C_IDLE;
      sdaLow_r <= 1'h0;
    end else begin
      unique case (state_r)
        I2C_IDLE: begin
          sdaLow_r <= 1'h0;
        end
        I2C_ADDR, I2C_REG, I2C_WDATA: begin
          if (sclRise) begin
            shift_r <= {shift_r[6:0], sdaF};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (byteDone) begin
            bitCnt_r <= '0;
            if (state_r != I2C_ADDR) begin
              sdaLow_r <= 1'h1;
              state_r <= (state_r == I2C_REG) ? I2C_ACK_REG : I2C_ACK_WDATA;
              if (state_r == I2C_REG) begin
                regAddr_r <= shift_r;
              end
            end else if (shift_r[7:1] == DEV_ADDR) begin
              sdaLow_r <= 1'h1;
              readMode_r <= shift_r[0];
              state_r <= I2C_ACK_ADDR;
            end else begin
              state_r <= I2C_IDLE;
            end
          end
        end
        I2C_ACK_ADDR: begin
          if (sclFall) begin
            if (readMode_r) begin
              shift_r <= rdData;
              sdaLow_r <= ~rdData[7];
              state_r <= I2C_RDATA;
            end else begin
              sdaLow_r <= 1'h0;
              state_r <= I2C_REG;
            end
          end
        end
        I2C_ACK_REG: begin
          if (sclFall) begin
            sdaLow_r <= 1'h0;
            state_r <= I2C_WDATA;
          end
        end
        I2C_ACK_WDATA: begin
          if (sclFall) begin
            sdaLow_r <= 1'h0;
            regAddr_r <= regAddr_r + 8'h01;
            state_r <= I2C_WDATA;
          end
        end
        I2C_RDATA: begin
          if (sclRise) begin
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (byteDone) begin
            bitCnt_r <= '0;
            sdaLow_r <= 1'h0;
            state_r <= I2C_ACK_RDATA;
          end else if (sclFall) begin
            shift_r <= {shift_r[6:0], 1'h0};
            sdaLow_r <= ~shift_r[6];
          end
        end
        I2C_ACK_RDATA: begin
          if (sclRise) begin
            if (sdaF) begin
              state_r <= I2C_IDLE;
            end else begin
              regAddr_r <= regAddr_r + 8'h01;
            end
          end else if (sclFall) begin
            shift_r <= rdData;
            sdaLow_r <= ~rdData[7];
            state_r <= I2C_RDATA;
          end
        end
      endcase
    end
  end

  assign sdaOut = 1'h0;
  assign sdaOe = sdaLow_r;

  // Read mux, unmapped addresses read as zero
  always_comb begin
    case (regAddr_r)
      `PCR_ADDR_DEVICE_CONFIG: rdData = devCfg_r;
      `PCR_ADDR_CLOCK_SYNC_CONTROL: rdData = clkCtl_r;
      `PCR_ADDR_POWER_GOOD_CONTROL: rdData = pgCtl_r;
      default: rdData = `PCR_UNMAPPED_DATA;
    endcase
  end

  // Register file, reserved bits never store and read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      devCfg_r <= `PCR_REG_RESET;
      clkCtl_r <= `PCR_REG_RESET;
      pgCtl_r <= `PCR_REG_RESET;
    end else if (regWrite) begin
      if (regAddr_r == `PCR_ADDR_DEVICE_CONFIG) begin
        devCfg_r <= shift_r & `PCR_CFG_WRITE_MASK;
      end
      if (regAddr_r == `PCR_ADDR_CLOCK_SYNC_CONTROL) begin
        clkCtl_r <= shift_r & `PCR_PLL_WRITE_MASK;
      end
      if (regAddr_r == `PCR_ADDR_POWER_GOOD_CONTROL) begin
        pgCtl_r <= shift_r & `PCR_PG_WRITE_MASK;
      end
    end
  end

  // Configuration outputs
  assign secondGeneralOutputOe = ~devCfg_r[`PCR_CFG_PIN_FUNCTION];
  assign clockPinPulldownEnable = devCfg_r[`PCR_CFG_CLOCK_PIN_PD];
  assign enablePinPulldownEnable = devCfg_r[`PCR_CFG_ENABLE_PIN_PD];
  assign thermalWarningThresholdSelect = devCfg_r[`PCR_CFG_THERMAL_LEVEL];
  assign spreadModulationEnable = devCfg_r[`PCR_CFG_SPREAD];
  assign pllEnable = clkCtl_r[`PCR_PLL_ENABLE];
  // Reserved codes above 0x17 pass through unchecked
  assign expectedClockMhz = {1'h0, clkCtl_r[`PCR_PLL_FREQ_MSB:0]} + `PCR_FREQ_OFFSET;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gpoOut_r <= 1'h0;
    end else begin
      gpoOut_r <= secondGeneralOutputLevel;
    end
  end

  assign secondGeneralOutput = gpoOut_r;

  // Clock source selection
  pcr_clock_monitor #(
    .LOSS_CYC(LOSS_CYC)
  ) u_clock_monitor (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .externalClockInputPin(externalClockInputPin),
    .pllEnable(pllEnable),
    .pinIsClock(devCfg_r[`PCR_CFG_PIN_FUNCTION]),
    .useExternalClock(useExternalClock),
    .clockEventPulse(clockEventPulse)
  );

  // Startup and shutdown delays from the enable pin edges
  assign upIf.start = enF & ~enPrev_r;
  assign upIf.code = startupDelayCode;
  assign upIf.wideStep = devCfg_r[`PCR_CFG_STARTUP_RANGE];
  assign downIf.start = ~enF & enPrev_r;
  assign downIf.code = shutdownDelayCode;
  assign downIf.wideStep = devCfg_r[`PCR_CFG_SHUTDOWN_RANGE];

  pcr_delay_timer #(
    .STEP_CYC(STEP_CYC)
  ) u_startup_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .dly(upIf.timer)
  );

  pcr_delay_timer #(
    .STEP_CYC(STEP_CYC)
  ) u_shutdown_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .dly(downIf.timer)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enPrev_r <= 1'h0;
      seqEn_r <= 1'h0;
    end else begin
      enPrev_r <= enF;
      if (upIf.done && enF) begin
        seqEn_r <= 1'h1;
      end else if (downIf.done && !enF) begin
        seqEn_r <= 1'h0;
      end
    end
  end

  assign sequencedEnable = seqEn_r;

  // Power-good evaluation
  assign windowMask = {{2{pgCtl_r[`PCR_PG_LINEAR_WINDOW]}}, {2{pgCtl_r[`PCR_PG_SWITCHER_WINDOW]}}};
  assign railOk = ~underF & ~(overF & windowMask);
  assign allGood = &(railOk | ~pgCtl_r[`PCR_PG_SOURCE_MSB:0]);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pgLevel_r <= 1'h0;
      pgOut_r <= 1'h0;
      pgOe_r <= 1'h0;
    end else begin
      pgLevel_r <= allGood ^ pgCtl_r[`PCR_PG_POLARITY];
      pgOut_r <= pgCtl_r[`PCR_PG_OPEN_DRAIN] ? 1'h0 : pgLevel_r;
      pgOe_r <= pgCtl_r[`PCR_PG_OPEN_DRAIN] ? ~pgLevel_r : 1'h1;
    end
  end

  assign powerOkOutput = pgOut_r;
  assign powerOkOe = pgOe_r;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_pin_function;
    regWrite && regAddr_r == `PCR_ADDR_DEVICE_CONFIG |=>
      secondGeneralOutputOe == !$past(shift_r[`PCR_CFG_PIN_FUNCTION]);
  endproperty
  a_pin_function: assert property (p_pin_function) else $error("pin function not applied");

  property p_clock_pin_pd;
    regWrite && regAddr_r == `PCR_ADDR_DEVICE_CONFIG |=>
      clockPinPulldownEnable == $past(shift_r[`PCR_CFG_CLOCK_PIN_PD]);
  endproperty
  a_clock_pin_pd: assert property (p_clock_pin_pd) else $error("clock pin pull-down wrong");

  property p_enable_pin_pd;
    !regWrite [*2] |-> $stable(enablePinPulldownEnable);
  endproperty
  a_enable_pin_pd: assert property (p_enable_pin_pd) else $error("enable pull-down changed alone");

  property p_thermal_spread;
    regWrite && regAddr_r == `PCR_ADDR_DEVICE_CONFIG |=>
      {thermalWarningThresholdSelect, spreadModulationEnable} == $past(shift_r[1:0]);
  endproperty
  a_thermal_spread: assert property (p_thermal_spread) else $error("thermal or spread wrong");

  property p_freq_code;
    regWrite && regAddr_r == `PCR_ADDR_CLOCK_SYNC_CONTROL |=>
      expectedClockMhz == {1'h0, $past(shift_r[4:0])} + 6'h01;
  endproperty
  a_freq_code: assert property (p_freq_code) else $error("frequency code wrong");

  property p_no_sources;
    (pgCtl_r[3:0] == 4'h0 && !pgCtl_r[`PCR_PG_OPEN_DRAIN] && $stable(pgCtl_r)) [*3] |->
      powerOkOutput == !pgCtl_r[`PCR_PG_POLARITY];
  endproperty
  a_no_sources: assert property (p_no_sources) else $error("power good wrong with no sources");

  property p_open_drain;
    (pgCtl_r[`PCR_PG_OPEN_DRAIN] && $stable(pgCtl_r)) [*2] |-> !powerOkOutput;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

  property p_rail_fault;
    (|(pgCtl_r[3:0] & (underF | (overF & windowMask))) && !pgCtl_r[`PCR_PG_OPEN_DRAIN]
      && $stable(pgCtl_r)) [*3] |-> powerOkOutput == pgCtl_r[`PCR_PG_POLARITY];
  endproperty
  a_rail_fault: assert property (p_rail_fault) else $error("fault not reported");

  c_reg_write: cover property (regWrite && regAddr_r == `PCR_ADDR_POWER_GOOD_CONTROL);
  c_reg_read: cover property (state_r == I2C_RDATA && sclRise);
  c_power_good: cover property ($rose(powerOkOutput));
  c_sequenced: cover property ($rose(sequencedEnable));
endmodule

// ===== verification/pcr_host_model.sv
// Serial management bus host that drives the configuration block
`timescale 1ns/10ps
module pcr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h60
) (
  // Clock
  input wire logic core_clk,
  // Bus lines, data is open drain with a pull-up
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaPull
);
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic half();
    repeat (10) @(posedge core_clk);
  endtask
  task automatic bitx(input logic b, output logic r);
    half();
    sdaPull <= ~b;
    half();
    sclOut <= 1'b1;
    half();
    r = sdaWire;
    sclOut <= 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
  endtask
  task automatic start();
    half();
    sdaPull <= 1'b0;
    half();
    sclOut <= 1'b1;
    half();
    sdaPull <= 1'b1;
    half();
    sclOut <= 1'b0;
  endtask
  task automatic stop();
    half();
    sdaPull <= 1'b1;
    half();
    sclOut <= 1'b1;
    half();
    sdaPull <= 1'b0;
    half();
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    sendByte({DEV_ADDR, 1'b0});
    sendByte(a);
    sendByte(d);
    stop();
  endtask
  // Single byte read, ended by a host NACK
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    sendByte({DEV_ADDR, 1'b0});
    sendByte(a);
    start();
    sendByte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, r);
    stop();
  endtask
endmodule

// ===== verification/pcr_config_regs_test.sv
// Self-checking bench for the configuration block
`timescale 1ns/10ps
module pcr_config_regs_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic enablePin = 1'b0;
  logic extClk = 1'b0;
  logic gpoLevel = 1'b0;
  logic [3:0] upCode = 4'h0;
  logic [3:0] downCode = 4'h0;
  logic [3:0] underV = 4'h0;
  logic [3:0] overV = 4'h0;
  logic sclOut, sdaPull, sdaOut, sdaOe, epd, seqEn, gpo, gpoOe, cpd, pllEn, useExt, clkEvt, therm, spread, pgOut, pgOe;
  logic [5:0] mhz;
  logic [7:0] rdata;
  wire sdaWire = ~(sdaPull | sdaOe);
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int events = 0;
  pcr_config_regs #(.STEP_CYC(4), .LOSS_CYC(8)) i_pcr_config_regs (.core_clk(core_clk), .rst_n(rst_n),
    .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .enablePin(enablePin),
    .startupDelayCode(upCode), .shutdownDelayCode(downCode), .enablePinPulldownEnable(epd),
    .sequencedEnable(seqEn), .externalClockInputPin(extClk), .secondGeneralOutputLevel(gpoLevel),
    .secondGeneralOutput(gpo), .secondGeneralOutputOe(gpoOe), .clockPinPulldownEnable(cpd),
    .pllEnable(pllEn), .useExternalClock(useExt), .clockEventPulse(clkEvt), .expectedClockMhz(mhz),
    .thermalWarningThresholdSelect(therm), .spreadModulationEnable(spread), .railUnderVoltage(underV),
    .railOverVoltage(overV), .powerOkOutput(pgOut), .powerOkOe(pgOe));
  pcr_host_model i_pcr_host_model (.core_clk(core_clk), .sdaWire(sdaWire), .sclOut(sclOut), .sdaPull(sdaPull));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    events += int'(clkEvt === 1'b1);
    if (cycles == 60000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    i_pcr_host_model.read_reg(a, rdata);
    check(rdata, exp);
  endtask
  task automatic test_reset();
    for (int a = 8'h13; a <= 8'h15; a++) rdChk(a[7:0], 8'h00);
    check({4'h0, pllEn, useExt, gpoOe, pgOe}, 8'h03);
    i_pcr_host_model.write_reg(8'h16, 8'hFF);
    rdChk(8'h16, 8'h00);
  endtask
  task automatic test_config();
    gpoLevel <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      i_pcr_host_model.write_reg(8'h13, 8'h01 << i);
      rdChk(8'h13, 8'h01 << i);
      check({3'h0, ~gpoOe, cpd, epd, therm, spread}, 8'h01 << i);
      check({7'h00, gpo}, 8'h01);
    end
  endtask
  task automatic test_freq();
    for (int c = 0; c <= 8'h17; c += 8'h17) begin
      i_pcr_host_model.write_reg(8'h14, 8'h40 | c[7:0]);
      check({2'h0, mhz}, c[7:0] + 8'h01);
      check({7'h00, pllEn}, 8'h01);
    end
  endtask
  task automatic toggle();
    // Two cycles a level so the pin filter sees each one
    repeat (20) begin
      extClk <= ~extClk;
      tick(2);
    end
  endtask
  task automatic test_clock();
    i_pcr_host_model.write_reg(8'h13, 8'h10);
    i_pcr_host_model.write_reg(8'h14, 8'h40);
    events = 0;
    toggle();
    check({7'h00, useExt}, 8'h01);
    tick(20);
    check({7'h00, useExt}, 8'h00);
    check(events[7:0], 8'h02);
    i_pcr_host_model.write_reg(8'h14, 8'h00);
    toggle();
    check({7'h00, useExt}, 8'h00);
    check(events[7:0], 8'h02);
  endtask
  // Pin edge to output change, n cycles including the input filter
  task automatic delayCase(input logic lvl, input int n);
    enablePin <= lvl;
    tick(n - 2);
    check({7'h00, seqEn}, {7'h00, ~lvl});
    tick(3);
    check({7'h00, seqEn}, {7'h00, lvl});
  endtask
  task automatic test_delay();
    i_pcr_host_model.write_reg(8'h13, 8'h40);
    upCode <= 4'h3;
    downCode <= 4'hF;
    delayCase(1'b1, 30);
    delayCase(1'b0, 66);
    i_pcr_host_model.write_reg(8'h13, 8'h20);
    upCode <= 4'h0;
    downCode <= 4'h1;
    delayCase(1'b1, 6);
    delayCase(1'b0, 14);
  endtask
  task automatic pgCase(input logic [7:0] ctl, input logic [3:0] uv, input logic [3:0] ov, input logic [7:0] exp);
    underV <= uv;
    overV <= ov;
    i_pcr_host_model.write_reg(8'h15, ctl);
    tick(10);
    check({6'h00, pgOut, pgOe}, exp);
  endtask
  task automatic test_power_ok_output();
    pgCase(8'h0F, 4'h0, 4'h0, 8'h03);
    pgCase(8'h0F, 4'h0, 4'h4, 8'h03);
    pgCase(8'h2F, 4'h0, 4'h4, 8'h01);
    pgCase(8'h0F, 4'h0, 4'h1, 8'h03);
    pgCase(8'h1F, 4'h0, 4'h1, 8'h01);
    pgCase(8'h0B, 4'h4, 4'h0, 8'h03);
    pgCase(8'h0F, 4'h4, 4'h0, 8'h01);
    pgCase(8'h8F, 4'h0, 4'h0, 8'h01);
    pgCase(8'h4F, 4'h0, 4'h0, 8'h00);
    pgCase(8'h4F, 4'h8, 4'h0, 8'h01);
    rdChk(8'h15, 8'h4F);
  endtask
  initial begin
    tick(5);
    rst_n <= 1'b1;
    tick(5);
    test_reset();
    test_config();
    test_freq();
    test_clock();
    test_delay();
    test_power_ok_output();
    finish_test();
  end
endmodule
